/* rtl/epe_defines.svh */
// epe_defines.svh: offsets, codes and counts of the parallel port engine
// assumes: included by its bare name; holds definitions only
`ifndef EPE_DEFINES_SVH
`define EPE_DEFINES_SVH

// mode field codes
`define EPE_MODE_SPP       3'h0
`define EPE_MODE_BYTE      3'h1
`define EPE_MODE_FIFO      3'h2
`define EPE_MODE_ECP       3'h3
`define EPE_MODE_RESET     3'h0

// queue geometry and threshold
`define EPE_DEPTH          5'h10
`define EPE_PTR_W          4
`define EPE_THR_OFFSET     5'h01
`define EPE_LEVEL_RESET    4'h0

// run-length command layout
`define EPE_CMD_KIND_BIT   7
`define EPE_CMD_VAL_MSB    6

// dma request pacing and serial request frame
`define EPE_DMA_BURST_MAX  6'h20
`define EPE_DMA_CHANNEL    3'h3
`define EPE_LDRQ_LEN       3'h5

`endif

/* rtl/epe_pkg.sv */
// epe_pkg.sv: types shared by the parallel port engine
// assumes: compiled before the engine module
package epe_pkg;

   // one queue entry: a byte and whether it travels as a command
   typedef struct packed {
      logic       is_cmd;
      logic [7:0] value;
   } epe_entry_t;

   // the four control lines and their output enables
   typedef struct packed {
      logic strobe_n;
      logic auto_feed_n;
      logic init_n;
      logic select_in_n;
   } epe_ctl_t;

   // handshake engine states
   typedef enum logic [2:0] {
      ST_IDLE, ST_SETUP, ST_STROBE, ST_RELEASE,
      ST_REV_WAIT, ST_REV_ACK, ST_REPEAT
   } epe_state_t;

endpackage

/* rtl/epe_engine.sv */
// epe_engine.sv: ecp parallel port engine with queue, handshake,
// run-length expansion, service/fault/ack interrupts and dma requests
// assumes: one 40 MHz clock, software bits arrive as plain ports from
// same-clock logic, pins from the peripheral are asynchronous
//
// Overview of operation
// - leave a mode only via 000 or 001; others may only return there
// - direction changes honoured only in mode 001
// - modes 010/011 run hardware handshake; 000/001 lines follow software
// - address queue bytes go as commands in mode 011 (as data in 010), data queue bytes as data
// - reverse ecp handshakes each incoming byte, queueing data bytes only
// - forward hostack high for data, low for command bytes
// - command bit 7 low is run-length count, high is channel address
// - reverse periphack high is data, low is command; channels dropped
// - run-length count n repeats the following data byte n+1 times
// - control line drivers open-drain in mode 000, push-pull otherwise
// - mask set blocks dma and service irqs; clearing re-raises at once
// - terminal count with dma permitted raises irq and sets mask
// - forward pio irq when free space reaches fill request level
// - reverse pio irq when queue holds drain request level bytes
// - fault falling edge, or disable cleared while fault low, interrupts
// - acknowledge rising edge interrupts when enabled
// - effective threshold is level setting plus one
// - dma request on ldrq encoding, at most 32 cycles in a row
// - mode 000 holds queue in reset; 001 byte, 010 fifo, 011 ecp
// - any service interrupt sets the mask bit in hardware
`timescale 1ns/100ps
`default_nettype none
`include "epe_defines.svh"

module epe_engine
   import epe_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   // software control
   input  wire logic       mode_wr,
   input  wire logic [2:0] mode_wdata,
   input  wire logic       dir_wr,
   input  wire logic       dir_wdata,
   input  wire epe_ctl_t   sw_ctl,
   input  wire logic       mask_wr,
   input  wire logic       mask_wdata,
   input  wire logic       dma_permit,
   input  wire logic       fault_irq_disable_n,
   input  wire logic       ack_edge_irq_on,
   input  wire logic [3:0] queue_level_setting,
   // programmed queue access
   input  wire logic       address_rle_queue_wr,
   input  wire logic       ecp_data_queue_wr,
   input  wire logic [7:0] queue_wdata,
   input  wire logic       ecp_data_queue_rd,
   output logic [7:0]      queue_rdata,
   // host dma cycle and terminal count
   input  wire logic       dma_cycle,
   input  wire logic [7:0] dma_wdata,
   input  wire logic       dma_tc,
   output logic            ldrq_n,
   // status and interrupts
   output logic [2:0]      mode,
   output logic            direction,
   output logic            service_irq_mask,
   output logic            queue_full,
   output logic            queue_empty,
   output logic            service_irq,
   output logic            fault_irq,
   output logic            ack_irq,
   // parallel pins
   input  wire logic [7:0] pd_in,
   output logic [7:0]      pd_out,
   output logic [7:0]      pd_oe,
   output epe_ctl_t        ctl_out,
   output epe_ctl_t        ctl_oe,
   input  wire logic       busy_in,
   input  wire logic       peripheral_ack_n,
   input  wire logic       peripheral_fault_n
);

   logic [2:0]        mode_ff;
   logic              dir_ff;
   logic              mask_ff;
   logic              disable_q_ff;
   epe_entry_t        mem_ff [0:15];
   logic [3:0]        wptr_ff, rptr_ff;
   logic [4:0]        cnt_ff;
   logic [4:0]        nxt_cnt;
   logic [7:0]        rdata_ff;
   logic              full_ff, empty_ff;
   epe_state_t        st_ff;
   epe_entry_t        tx_ff;
   logic [7:0]        rep_ff, rep_left_ff, rx_byte_ff;
   logic [1:0]        busy_s_ff, ack_s_ff, fault_s_ff;
   logic [7:0]        pd_s1_ff, pd_s2_ff;
   logic              ack_d_ff, fault_d_ff;
   logic              svc_irq_ff, flt_irq_ff, ack_irq_ff;
   logic [5:0]        burst_ff;
   logic              hold_ff;
   logic              req_sent_ff;
   logic [4:0]        ldrq_sh_ff;
   logic [2:0]        ldrq_cnt_ff;
   logic              ldrq_ff;
   logic [7:0]        pd_out_ff, pd_oe_ff;
   epe_ctl_t          ctl_ff, ctl_oe_ff;

   // true for the two software-driven modes
   function automatic logic is_pio_mode(input logic [2:0] m);
      return (m == `EPE_MODE_SPP) || (m == `EPE_MODE_BYTE);
   endfunction

   wire logic auto_mode = (mode_ff == `EPE_MODE_ECP) ||
                          (mode_ff == `EPE_MODE_FIFO);
   wire logic [4:0] thr = {1'b0, queue_level_setting} + `EPE_THR_OFFSET;
   wire logic [4:0] free_cnt = `EPE_DEPTH - cnt_ff;
   wire logic busy_s = busy_s_ff[1];
   wire logic ack_s  = ack_s_ff[1];
   wire logic flt_s  = fault_s_ff[1];

   // mode and direction gate
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         mode_ff <= `EPE_MODE_RESET;
         dir_ff  <= 1'b0;
      end else begin
         if (mode_wr && (is_pio_mode(mode_ff) || is_pio_mode(mode_wdata)))
            mode_ff <= mode_wdata;
         if (dir_wr && mode_ff == `EPE_MODE_BYTE)
            dir_ff <= dir_wdata;
      end
   end

   // pin synchronisers: first stage is read by the second only
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         busy_s_ff  <= 2'b00;
         ack_s_ff   <= 2'b11;
         fault_s_ff <= 2'b11;
         pd_s1_ff   <= 8'h00;
         pd_s2_ff   <= 8'h00;
      end else begin
         busy_s_ff  <= {busy_s_ff[0], busy_in};
         ack_s_ff   <= {ack_s_ff[0], peripheral_ack_n};
         fault_s_ff <= {fault_s_ff[0], peripheral_fault_n};
         pd_s1_ff   <= pd_in;
         pd_s2_ff   <= pd_s1_ff;
      end
   end

   // queue push and pop sources
   wire logic fwd = !dir_ff;
   wire logic dma_go = dma_cycle && auto_mode;
   wire logic rev_push = (st_ff == ST_REV_ACK && ack_s && rx_byte_ff == 8'h00)
                         || (st_ff == ST_REPEAT && rep_left_ff != 8'h00);
   wire logic host_push = fwd && (address_rle_queue_wr ||
                          ecp_data_queue_wr || dma_go);
   wire logic push = (host_push || (rev_push && !fwd)) && !full_ff;
   wire logic eng_pop = (st_ff == ST_IDLE) && fwd && auto_mode && !empty_ff;
   wire logic host_pop = !fwd && (ecp_data_queue_rd || dma_go);
   wire logic pop = (eng_pop || host_pop) && !empty_ff;
   epe_entry_t push_entry;

   // entry written this cycle: host command, host data or received byte
   always_comb begin
      push_entry.is_cmd = fwd && address_rle_queue_wr &&
                          mode_ff == `EPE_MODE_ECP;
      if (!fwd)
         push_entry.value = rep_ff;
      else if (dma_go)
         push_entry.value = dma_wdata;
      else
         push_entry.value = queue_wdata;
      nxt_cnt = cnt_ff + {4'h0, push} - {4'h0, pop};
   end

   // queue storage and pointers; mode 000 keeps it in reset
   always_ff @(posedge ref_clk) begin
      if (!resetn || mode_ff == `EPE_MODE_SPP) begin
         wptr_ff  <= 4'h0;
         rptr_ff  <= 4'h0;
         cnt_ff   <= 5'h00;
         full_ff  <= 1'b0;
         empty_ff <= 1'b1;
         rdata_ff <= 8'h00;
      end else begin
         if (push) begin
            mem_ff[wptr_ff] <= push_entry;
            wptr_ff <= wptr_ff + 4'h1;
         end
         if (pop) begin
            rptr_ff <= rptr_ff + 4'h1;
            if (host_pop)
               rdata_ff <= mem_ff[rptr_ff].value;
         end
         cnt_ff   <= nxt_cnt;
         full_ff  <= nxt_cnt == `EPE_DEPTH;
         empty_ff <= nxt_cnt == 5'h00;
      end
   end

   // handshake engine: forward sends, reverse receives and expands
   always_ff @(posedge ref_clk) begin
      if (!resetn || !auto_mode) begin
         st_ff       <= ST_IDLE;
         tx_ff       <= '0;
         rep_ff      <= 8'h00;
         rep_left_ff <= 8'h00;
         rx_byte_ff  <= 8'h00;
      end else begin
         unique case (st_ff)
            ST_IDLE: begin
               if (!fwd && mode_ff == `EPE_MODE_ECP)
                  st_ff <= ST_REV_WAIT;
               else if (eng_pop) begin
                  tx_ff <= mem_ff[rptr_ff];
                  st_ff <= ST_SETUP;
               end
            end
            ST_SETUP:   st_ff <= ST_STROBE;
            ST_STROBE:  if (busy_s) st_ff <= ST_RELEASE;
            ST_RELEASE: if (!busy_s) st_ff <= ST_IDLE;
            ST_REV_WAIT: begin
               if (!ack_s && !full_ff) begin
                  rep_ff <= pd_s2_ff;
                  // busy low marks a command byte
                  rx_byte_ff <= busy_s ? 8'h00 : 8'h01;
                  st_ff <= ST_REV_ACK;
               end
            end
            ST_REV_ACK: begin
               if (ack_s) begin
                  if (rx_byte_ff != 8'h00) begin
                     // channel addresses are dropped, counts kept
                     if (!rep_ff[`EPE_CMD_KIND_BIT])
                        rep_left_ff <= {1'b0,
                                        rep_ff[`EPE_CMD_VAL_MSB:0]};
                     st_ff <= ST_REV_WAIT;
                  end else
                     st_ff <= ST_REPEAT;
               end
            end
            ST_REPEAT: begin
               // count n yields n more copies after the first
               if (rep_left_ff == 8'h00)
                  st_ff <= ST_REV_WAIT;
               else if (!full_ff)
                  rep_left_ff <= rep_left_ff - 8'h01;
            end
            default: st_ff <= ST_IDLE;
         endcase
      end
   end

   // pin drivers, registered so every pin comes from a flop
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         pd_out_ff <= 8'h00;
         pd_oe_ff  <= 8'h00;
         // low with enables off, so the first open-drain cycle agrees
         ctl_ff    <= '0;
         ctl_oe_ff <= '0;
      end else begin
         epe_ctl_t lines;
         lines = sw_ctl;
         if (auto_mode) begin
            lines.strobe_n = (st_ff != ST_STROBE);
            if (mode_ff == `EPE_MODE_ECP)
               lines.auto_feed_n = fwd ? !tx_ff.is_cmd
                                       : (st_ff == ST_REV_ACK);
         end
         pd_out_ff <= tx_ff.value;
         if (!auto_mode)
            pd_out_ff <= rdata_ff;
         pd_oe_ff <= (mode_ff == `EPE_MODE_SPP || fwd) ? 8'hff : 8'h00;
         if (mode_ff == `EPE_MODE_SPP) begin
            // open drain: drive only the low level
            ctl_ff    <= '0;
            ctl_oe_ff <= ~lines;
         end else begin
            ctl_ff    <= lines;
            ctl_oe_ff <= '1;
         end
      end
   end

   // service condition: tc in dma, thresholds in programmed mode
   wire logic pio_cond = !dma_permit && auto_mode &&
        (fwd ? (free_cnt >= thr) : (cnt_ff >= thr));
   wire logic tc_cond = dma_permit && dma_tc;
   wire logic svc_evt = !mask_ff && (pio_cond || tc_cond);

   // mask bit: hardware set wins over a software clear
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         mask_ff    <= 1'b1;
         svc_irq_ff <= 1'b0;
      end else begin
         svc_irq_ff <= svc_evt;
         if (svc_evt)
            mask_ff <= 1'b1;
         else if (mask_wr)
            mask_ff <= mask_wdata;
      end
   end

   // fault and acknowledge edge interrupts
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         ack_d_ff     <= 1'b1;
         fault_d_ff   <= 1'b1;
         disable_q_ff <= 1'b1;
         flt_irq_ff   <= 1'b0;
         ack_irq_ff   <= 1'b0;
      end else begin
         ack_d_ff     <= ack_s;
         fault_d_ff   <= flt_s;
         disable_q_ff <= fault_irq_disable_n;
         flt_irq_ff   <= !fault_irq_disable_n &&
                         ((fault_d_ff && !flt_s) ||
                          (disable_q_ff && !flt_s));
         ack_irq_ff   <= ack_edge_irq_on && !ack_d_ff && ack_s;
      end
   end

   // dma request level with a forced gap after 32 cycles in a row
   wire logic dma_want = auto_mode && dma_permit && !mask_ff &&
                         (fwd ? !full_ff : !empty_ff) && !hold_ff;
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         burst_ff <= 6'h00;
         hold_ff  <= 1'b0;
      end else begin
         if (!dma_want)
            burst_ff <= 6'h00;
         else if (dma_cycle)
            burst_ff <= burst_ff + 6'h01;
         // hold until the withdrawal frame has gone out
         if (dma_want && dma_cycle &&
             burst_ff == `EPE_DMA_BURST_MAX - 6'h01)
            hold_ff <= 1'b1;
         else if (hold_ff && !req_sent_ff && ldrq_cnt_ff == 3'h0)
            hold_ff <= 1'b0;
      end
   end

   // serial request frame: start low, channel msb first, active bit
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         req_sent_ff <= 1'b0;
         ldrq_sh_ff  <= 5'h1f;
         ldrq_cnt_ff <= 3'h0;
         ldrq_ff     <= 1'b1;
      end else if (ldrq_cnt_ff != 3'h0) begin
         ldrq_ff     <= ldrq_sh_ff[4];
         ldrq_sh_ff  <= {ldrq_sh_ff[3:0], 1'b1};
         ldrq_cnt_ff <= ldrq_cnt_ff - 3'h1;
      end else begin
         ldrq_ff <= 1'b1;
         if (dma_want != req_sent_ff) begin
            req_sent_ff <= dma_want;
            ldrq_sh_ff  <= {1'b0, `EPE_DMA_CHANNEL, dma_want};
            ldrq_cnt_ff <= `EPE_LDRQ_LEN;
         end
      end
   end

   assign mode             = mode_ff;
   assign direction        = dir_ff;
   assign service_irq_mask = mask_ff;
   assign queue_full       = full_ff;
   assign queue_empty      = empty_ff;
   assign queue_rdata      = rdata_ff;
   assign service_irq      = svc_irq_ff;
   assign fault_irq        = flt_irq_ff;
   assign ack_irq          = ack_irq_ff;
   assign ldrq_n           = ldrq_ff;
   assign pd_out           = pd_out_ff;
   assign pd_oe            = pd_oe_ff;
   assign ctl_out          = ctl_ff;
   assign ctl_oe           = ctl_oe_ff;

   // checks
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   mode_gate_a: assert property (
      !is_pio_mode($past(mode_ff)) && mode_ff != $past(mode_ff)
      |-> is_pio_mode(mode_ff)) else $error("illegal mode change");
   dir_gate_a: assert property (
      dir_ff != $past(dir_ff) |-> $past(mode_ff) == `EPE_MODE_BYTE)
      else $error("direction changed outside byte mode");
   mask_set_a: assert property (
      svc_irq_ff |-> mask_ff) else $error("mask not set by irq");
   svc_block_a: assert property (
      $past(mask_ff) |-> !svc_irq_ff) else $error("irq while masked");
   tc_irq_a: assert property (
      !mask_ff && dma_permit && dma_tc |=> svc_irq_ff && mask_ff)
      else $error("tc did not interrupt");
   unmask_irq_a: assert property (
      !mask_ff && pio_cond |=> svc_irq_ff)
      else $error("threshold irq missed");
   queue_reset_a: assert property (
      mode_ff == `EPE_MODE_SPP |=> empty_ff && cnt_ff == 5'h00)
      else $error("queue not reset in mode 000");
   open_drain_a: assert property (
      $past(mode_ff) == `EPE_MODE_SPP |-> (ctl_ff == '0))
      else $error("control line driven high in mode 000");
   burst_cap_a: assert property (
      burst_ff <= `EPE_DMA_BURST_MAX) else $error("dma burst too long");
   ack_edge_a: assert property (
      ack_irq_ff |-> $past(ack_edge_irq_on,2) || $past(ack_edge_irq_on))
      else $error("ack irq while disabled");
   hostack_a: assert property (
      st_ff == ST_STROBE && fwd && mode_ff == `EPE_MODE_ECP
      ##1 st_ff == ST_STROBE |-> ctl_ff.auto_feed_n == !tx_ff.is_cmd)
      else $error("hostack does not match byte kind");

   fwd_send_c: cover property (st_ff == ST_SETUP ##[1:20] st_ff == ST_IDLE);
   rle_c:      cover property (st_ff == ST_REPEAT && rep_left_ff > 8'h01);
   tc_c:       cover property (tc_cond && !mask_ff);
   hold_c:     cover property (hold_ff);

endmodule
`default_nettype wire

/* sim/epe_periph.sv */
// epe_periph.sv: behavioural ecp peripheral on the engine's pins
// assumes: engine pins on ref_clk; bench calls send() for reverse bytes
`timescale 1ns/100ps
`default_nettype none
module epe_periph
   import epe_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       slow,
   input  wire logic [7:0] pd_out,
   input  wire epe_ctl_t   ctl_out,
   input  wire epe_ctl_t   ctl_oe,
   output logic [7:0]      pd_in,
   output logic            busy_in,
   output logic            peripheral_ack_n,
   output logic            rx_stb,
   output epe_entry_t      rx_entry
);
   logic rev_on;
   epe_ctl_t lvl;
   // pin level as the cable sees it: released lines float high on pull-ups
   assign lvl = ctl_out | ~ctl_oe;
   initial begin
      pd_in = 8'h5a;
      busy_in = 1'b0;
      peripheral_ack_n = 1'b1;
      rx_stb = 1'b0;
      rx_entry = '0;
      rev_on = 1'b0;
   end
   // undriven data lines keep changing so a stale byte never looks valid
   always @(negedge ref_clk) if (!rev_on) pd_in <= ~pd_in;
   // forward: take the byte at strobe, host-ack low marks a command
   always begin
      @(negedge ref_clk);
      if (lvl.strobe_n === 1'b0) begin
         rx_entry <= '{~lvl.auto_feed_n, pd_out};
         rx_stb <= 1'b1;
         @(negedge ref_clk);
         rx_stb <= 1'b0;
         repeat (slow ? 5 : 0) @(negedge ref_clk);
         busy_in <= 1'b1;
         while (lvl.strobe_n !== 1'b1) @(negedge ref_clk);
         busy_in <= 1'b0;
      end
   end
   // reverse: periph-ack (busy) high for data, low for a command
   task automatic send(input epe_entry_t e);
      int n;
      rev_on = 1'b1;
      pd_in <= e.value;
      busy_in <= ~e.is_cmd;
      @(negedge ref_clk);
      peripheral_ack_n <= 1'b0;
      n = 0;
      while (lvl.auto_feed_n !== 1'b1 && n < 60) begin
         @(negedge ref_clk);
         n++;
      end
      peripheral_ack_n <= 1'b1;
      n = 0;
      while (lvl.auto_feed_n !== 1'b0 && n < 60) begin
         @(negedge ref_clk);
         n++;
      end
      rev_on = 1'b0;
   endtask
endmodule
`default_nettype wire

/* sim/test_ecp_parallel_port_engine.sv */
// test_ecp_parallel_port_engine.sv: self-checking bench for epe_engine
// assumes: epe_pkg compiled first, epe_periph on the pins
`timescale 1ns/100ps
`default_nettype none
module test_ecp_parallel_port_engine
   import epe_pkg::*;
;
   logic       ref_clk, resetn, mode_wr, dir_wr, dir_wdata, mask_wr;
   logic       mask_wdata, dma_permit, fault_irq_disable_n, slow;
   logic       ack_edge_irq_on, address_rle_queue_wr, ecp_data_queue_wr;
   logic       ecp_data_queue_rd, dma_cycle, dma_tc, peripheral_fault_n;
   logic       ldrq_n, direction, service_irq_mask, queue_full;
   logic       queue_empty, service_irq, fault_irq, ack_irq, busy_in;
   logic       peripheral_ack_n, rx_stb, rd_d;
   logic [2:0] mode_wdata, mode;
   logic [3:0] queue_level_setting, bits;
   logic [7:0] queue_wdata, dma_wdata, queue_rdata, pd_in, pd_out, pd_oe;
   logic [7:0] rnd;
   epe_ctl_t   sw_ctl, ctl_out, ctl_oe;
   epe_entry_t rx_entry;
   epe_entry_t exp_fwd[$];
   logic [7:0] exp_rd[$];
   int         miscompares, compares, cyc, n_svc, n_flt, n_ack, n0;

   epe_engine i_epe_engine (.ref_clk(ref_clk), .resetn(resetn),
      .mode_wr(mode_wr), .mode_wdata(mode_wdata), .dir_wr(dir_wr),
      .dir_wdata(dir_wdata), .sw_ctl(sw_ctl), .mask_wr(mask_wr),
      .mask_wdata(mask_wdata), .dma_permit(dma_permit),
      .fault_irq_disable_n(fault_irq_disable_n),
      .ack_edge_irq_on(ack_edge_irq_on),
      .queue_level_setting(queue_level_setting),
      .address_rle_queue_wr(address_rle_queue_wr),
      .ecp_data_queue_wr(ecp_data_queue_wr), .queue_wdata(queue_wdata),
      .ecp_data_queue_rd(ecp_data_queue_rd), .queue_rdata(queue_rdata),
      .dma_cycle(dma_cycle), .dma_wdata(dma_wdata), .dma_tc(dma_tc),
      .ldrq_n(ldrq_n), .mode(mode), .direction(direction),
      .service_irq_mask(service_irq_mask), .queue_full(queue_full),
      .queue_empty(queue_empty), .service_irq(service_irq),
      .fault_irq(fault_irq), .ack_irq(ack_irq), .pd_in(pd_in),
      .pd_out(pd_out), .pd_oe(pd_oe), .ctl_out(ctl_out), .ctl_oe(ctl_oe),
      .busy_in(busy_in), .peripheral_ack_n(peripheral_ack_n),
      .peripheral_fault_n(peripheral_fault_n));
   epe_periph i_epe_periph (.ref_clk(ref_clk), .slow(slow),
      .pd_out(pd_out), .ctl_out(ctl_out), .ctl_oe(ctl_oe), .pd_in(pd_in),
      .busy_in(busy_in), .peripheral_ack_n(peripheral_ack_n),
      .rx_stb(rx_stb), .rx_entry(rx_entry));

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic chk(input string nm, input logic [8:0] e, g);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic report_and_stop();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic set_mode(input logic [2:0] m, e);
      @(negedge ref_clk);
      mode_wr = 1'b1;
      mode_wdata = m;
      tick(1);
      mode_wr = 1'b0;
      chk("mode", {6'h00, e}, {6'h00, mode});
   endtask
   task automatic set_dir(input logic d, e);
      @(negedge ref_clk);
      dir_wr = 1'b1;
      dir_wdata = d;
      tick(1);
      dir_wr = 1'b0;
      chk("direction", {8'h00, e}, {8'h00, direction});
   endtask
   // queue write; the expectation is noted as the byte is handed over
   task automatic wr_q(input logic c, input logic [7:0] v);
      @(negedge ref_clk);
      address_rle_queue_wr = c;
      ecp_data_queue_wr = ~c;
      queue_wdata = v;
      exp_fwd.push_back('{c, v});
      tick(1);
      address_rle_queue_wr = 1'b0;
      ecp_data_queue_wr = 1'b0;
   endtask
   task automatic clr_mask();
      @(negedge ref_clk);
      mask_wr = 1'b1;
      mask_wdata = 1'b0;
      tick(1);
      mask_wr = 1'b0;
   endtask
   task automatic drain();
      int n;
      n = 0;
      while ((exp_fwd.size() != 0 || queue_empty !== 1'b1) && n < 400) begin
         tick(1);
         n++;
      end
   endtask

   // watcher: every result that appears is matched to the oldest note
   always @(posedge ref_clk) begin
      cyc++;
      if (service_irq === 1'b1) n_svc++;
      if (fault_irq === 1'b1) n_flt++;
      if (ack_irq === 1'b1) n_ack++;
      if (rx_stb === 1'b1)
         chk("sent", exp_fwd.size() ? exp_fwd.pop_front() : 9'h1ff,
             rx_entry);
      rd_d <= ecp_data_queue_rd & queue_empty === 1'b0;
      if (rd_d) chk("read", {1'b0, exp_rd.pop_front()},
                    {1'b0, queue_rdata});
      if (cyc == 30000) begin
         miscompares++;
         report_and_stop();
      end
   end

   initial begin
      {resetn, mode_wr, dir_wr, dir_wdata, mask_wr, mask_wdata} = '0;
      {dma_permit, ack_edge_irq_on, address_rle_queue_wr, slow} = '0;
      {ecp_data_queue_wr, ecp_data_queue_rd, dma_cycle, dma_tc} = '0;
      {mode_wdata, queue_wdata, dma_wdata, rd_d} = '0;
      {miscompares, compares, cyc, n_svc, n_flt, n_ack} = '0;
      fault_irq_disable_n = 1'b1;
      peripheral_fault_n = 1'b1;
      queue_level_setting = 4'h3;
      sw_ctl = 4'b1010;
      rnd = 8'h12;
      tick(6);
      resetn = 1'b1;
      tick(3);
      chk("reset mode", 9'h000, {6'h00, mode});
      chk("reset mask", 9'h001, {8'h00, service_irq_mask});
      chk("reset empty", 9'h001, {8'h00, queue_empty});
      chk("oe 000", 9'h005, {5'h00, ctl_oe});
      set_mode(3'h1, 3'h1);
      tick(2);
      chk("oe 001", 9'h00f, {5'h00, ctl_oe});
      sw_ctl = 4'b1111; // lines deasserted before ecp
      set_mode(3'h3, 3'h3);
      set_mode(3'h2, 3'h3);
      set_dir(1'b1, 1'b0);
      // count then byte, then a channel address and a second byte
      for (int i = 0; i < 2; i++) begin
         slow = i[0];
         rnd = lfsr(rnd);
         wr_q(1'b1, i ? 8'h85 : 8'h03);
         wr_q(1'b0, rnd);
         drain();
      end
      n0 = n_svc;
      clr_mask();
      tick(4);
      chk("fill irq", 9'h001, 9'(n_svc - n0));
      chk("mask set", 9'h001, {8'h00, service_irq_mask});
      // dma: permit first, then unmask
      dma_permit = 1'b1;
      tick(8);
      chk("masked ldrq", 9'h001, {8'h00, ldrq_n});
      clr_mask();
      for (int n = 0; n < 20 && ldrq_n !== 1'b0; n++) tick(1);
      for (int i = 0; i < 4; i++) begin
         tick(1);
         bits[i] = ldrq_n;
      end
      chk("ldrq frame", 9'h00e, {5'h00, bits});
      rnd = lfsr(rnd);
      dma_wdata = rnd;
      exp_fwd.push_back('{1'b0, rnd});
      dma_cycle = 1'b1;
      tick(1);
      dma_cycle = 1'b0;
      n0 = n_svc;
      dma_tc = 1'b1;
      tick(1);
      dma_tc = 1'b0;
      tick(3);
      chk("tc irq", 9'h001, 9'(n_svc - n0));
      chk("tc mask", 9'h001, {8'h00, service_irq_mask});
      dma_permit = 1'b0;
      drain();
      // reverse: back through 001, turn round, reselect ecp
      set_mode(3'h1, 3'h1);
      set_dir(1'b1, 1'b1);
      set_mode(3'h3, 3'h3);
      chk("pd oe rev", 9'h000, {1'b0, pd_oe});
      ack_edge_irq_on = 1'b1;
      rnd = lfsr(rnd);
      i_epe_periph.send('{1'b1, 8'h02});
      i_epe_periph.send('{1'b0, rnd});
      repeat (3) exp_rd.push_back(rnd);
      tick(4);
      n0 = n_svc;
      clr_mask();
      tick(4);
      chk("3 of 4", 9'h000, 9'(n_svc - n0));
      rnd = lfsr(rnd);
      i_epe_periph.send('{1'b1, 8'h00});
      i_epe_periph.send('{1'b0, rnd});
      exp_rd.push_back(rnd);
      tick(4);
      chk("drain irq", 9'h001, 9'(n_svc - n0));
      chk("ack irqs", 9'h001, {8'h00, n_ack > 0});
      while (queue_empty === 1'b0 && cyc < 29000) begin
         ecp_data_queue_rd = 1'b1;
         tick(1);
         ecp_data_queue_rd = 1'b0;
         tick(1);
      end
      tick(2);
      chk("reads left", 9'h000, 9'(exp_rd.size()));
      // fault: masked fall, then unmasking while low, then a fresh fall
      peripheral_fault_n = 1'b0;
      tick(8);
      chk("fault off", 9'h000, 9'(n_flt));
      fault_irq_disable_n = 1'b0;
      tick(6);
      chk("fault clr", 9'h001, 9'(n_flt));
      peripheral_fault_n = 1'b1;
      tick(6);
      peripheral_fault_n = 1'b0;
      tick(8);
      chk("fault fall", 9'h002, 9'(n_flt));
      report_and_stop();
   end
endmodule
`default_nettype wire
